//--- rtl/cpu_regs_regs.vh
// constants for the programmer-visible register set
`ifndef CPU_REGS_REGS_VH
`define CPU_REGS_REGS_VH
`define SP_RESET        16'h00FF
`define IDX_HI_RESET    8'h00
`define VEC_HI_ADDR     16'hFFFE
`define VEC_LO_ADDR     16'hFFFF
`define FLAG_FIXED_MASK 8'h60
`define FLAG_V          7
`define FLAG_H          4
`define FLAG_I          3
`define FLAG_N          2
`define FLAG_Z          1
`define FLAG_C          0
// x operation codes
`define XOP_NONE  4'h0
`define XOP_CLR   4'h1
`define XOP_INC   4'h2
`define XOP_DEC   4'h3
`define XOP_COM   4'h4
`define XOP_NEG   4'h5
`define XOP_LSL   4'h6
`define XOP_LSR   4'h7
`define XOP_ASR   4'h8
`define XOP_ROL   4'h9
`define XOP_ROR   4'hA
`define XOP_LOAD  4'hB
// address source selects
`define ASEL_PC     3'h0
`define ASEL_INDEX  3'h1
`define ASEL_DIRECT 3'h2
`define ASEL_PUSH   3'h3
`define ASEL_PULL   3'h4
`define ASEL_VEC_HI 3'h5
`define ASEL_VEC_LO 3'h6
`define ASEL_EXT    3'h7
`endif

//--- rtl/mul_div_unit.v
// multiply and divide datapath for accumulator and index registers
`default_nettype none
module mul_div_unit #(
   parameter W = 8
) (
   input  wire [W-1:0]   acc,
   input  wire [W-1:0]   idx_lo,
   input  wire [W-1:0]   idx_hi,
   output wire [2*W-1:0] product,
   output wire [W-1:0]   quotient,
   output wire [W-1:0]   remainder,
   output wire           div_fault
);
   wire [2*W-1:0] dividend;
   wire [2*W-1:0] full_q;
   wire [2*W-1:0] full_r;

   // 8x8 product, high byte to index low, low byte to acc
   assign product   = acc * idx_lo;
   // 16/8 divide of idx_hi:acc by idx_lo
   assign dividend  = {idx_hi, acc};
   assign full_q    = (idx_lo == {W{1'b0}}) ? {2*W{1'b1}}
                      : dividend / {{W{1'b0}}, idx_lo};
   assign full_r    = (idx_lo == {W{1'b0}}) ? {2*W{1'b0}}
                      : dividend % {{W{1'b0}}, idx_lo};
   assign quotient  = full_q[W-1:0];
   assign remainder = full_r[W-1:0];
   // divide by zero or quotient overflow sets carry
   assign div_fault = (idx_lo == {W{1'b0}}) | (|full_q[2*W-1:W]);
endmodule
`default_nettype wire

//--- rtl/cpu_register_set.v
// programmer-visible register set of the 8-bit core
// the sequencer drives one control strobe per cycle where it can; when
// several arrive together a fixed priority picks one per register, so a
// jump beats a branch, and a branch beats a plain fetch
// every control is ignored while the reset vector is being read, which
// costs two cycles after reset release before the first fetch counts
// the accumulator and the index low byte have no reset term on purpose:
// software may carry values across a reset, and a simulation shows them
// unknown until the first write
// push and pull only move the pointer; the sequencer must also pick the
// matching address source so the memory cycle lands on the right byte
// the stack pointer wraps at both ends of the address space silently
//
`include "cpu_regs_regs.vh"
`default_nettype none
module cpu_register_set (
   input  wire        clk,
   input  wire        arst_n,
   // sequencer controls
   input  wire        fetch,
   input  wire        pc_load,
   input  wire [15:0] pc_target,
   input  wire        branch_rel,
   input  wire [7:0]  rel_disp,
   input  wire        acc_load_alu,
   input  wire        acc_load_data,
   input  wire [7:0]  alu_result,
   input  wire [3:0]  x_op,
   input  wire        h_load,
   input  wire [7:0]  load_data,
   input  wire        mul_exec,
   input  wire        div_exec,
   input  wire        flags_load,
   input  wire [7:0]  flags_in,
   input  wire        stack_adjust_instr,
   input  wire [7:0]  stack_imm,
   input  wire        stack_low_reload_instr,
   input  wire        sp_load,
   input  wire        push,
   input  wire        pull,
   input  wire [2:0]  addr_sel,
   input  wire [7:0]  direct_addr,
   input  wire [15:0] ext_addr,
   input  wire [7:0]  mem_rdata,
   // register outputs
   output reg  [7:0]  acc,
   output reg  [7:0]  idx_hi,
   output reg  [7:0]  idx_lo,
   output wire [15:0] index_pair,
   output reg  [15:0] stack_pointer,
   output reg  [15:0] program_counter,
   output wire [7:0]  condition_flags,
   output wire [7:0]  alu_operand_a,
   output wire [15:0] mem_addr,
   output wire        vector_busy
);
   localparam [2:0] ST_VEC_HI = 3'b001;
   localparam [2:0] ST_VEC_LO = 3'b010;
   localparam [2:0] ST_RUN    = 3'b100;

   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [7:0]  vec_hi;
   reg  [7:0]  flags;
   reg  [7:0]  next_x;
   reg  [15:0] next_sp;
   wire [15:0] product;
   wire [7:0]  quotient;
   wire [7:0]  remainder;
   wire        div_fault;
   wire        x_carry_in;

   mul_div_unit #(.W(8)) u_mul_div (
      .acc       (acc),
      .idx_lo    (idx_lo),
      .idx_hi    (idx_hi),
      .product   (product),
      .quotient  (quotient),
      .remainder (remainder),
      .div_fault (div_fault)
   );

   // registers are visible only as ports; no memory decode here
   assign index_pair    = {idx_hi, idx_lo};
   assign alu_operand_a = acc;
   assign condition_flags = flags | `FLAG_FIXED_MASK;
   assign vector_busy   = ~state[2];
   assign x_carry_in    = flags[`FLAG_C];

   // address source mux for the single memory space
   assign mem_addr =
      (state == ST_VEC_HI)     ? `VEC_HI_ADDR :
      (state == ST_VEC_LO)     ? `VEC_LO_ADDR :
      (addr_sel == `ASEL_INDEX)  ? index_pair :
      (addr_sel == `ASEL_DIRECT) ? {8'h00, direct_addr} :
      (addr_sel == `ASEL_PUSH)   ? stack_pointer :
      (addr_sel == `ASEL_PULL)   ? stack_pointer + 16'h0001 :
      (addr_sel == `ASEL_EXT)    ? ext_addr :
      program_counter;

   // vector fetch sequencer after reset release
   // two states read the vector bytes; the third is normal running, and
   // any stray code falls back to the vector read rather than locking up
   always @*
   begin
      case (state)
         ST_VEC_HI: next_state = ST_VEC_LO;
         ST_VEC_LO: next_state = ST_RUN;
         ST_RUN:    next_state = ST_RUN;
         default:   next_state = ST_VEC_HI;
      endcase
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state  <= ST_VEC_HI;
         vec_hi <= 8'h00;
      end
      else
      begin
         state <= next_state;
         if (state == ST_VEC_HI)
            vec_hi <= mem_rdata;
      end
   end

   // program counter: vector, flow change, relative branch or increment
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         program_counter <= 16'h0000;
      else if (state == ST_VEC_LO)
         program_counter <= {vec_hi, mem_rdata};
      else if (state == ST_RUN)
      begin
         if (pc_load)
            program_counter <= pc_target;
         else if (branch_rel)
            program_counter <= program_counter
                               + {{8{rel_disp[7]}}, rel_disp};
         else if (fetch)
            program_counter <= program_counter + 16'h0001;
      end
   end

   // accumulator has no reset term, so reset leaves it alone
   always @(posedge clk)
   begin
      if (state == ST_RUN)
      begin
         if (mul_exec)
            acc <= product[7:0];
         else if (div_exec)
            acc <= quotient;
         else if (acc_load_alu)
            acc <= alu_result;
         else if (acc_load_data)
            acc <= load_data;
      end
   end

   // index low operations; low byte only, high byte untouched
   // rotates take the carry flag in but do not update it here; flag
   // results of these operations belong to the sequencer's flag write
   always @*
   begin
      case (x_op)
         `XOP_CLR:  next_x = 8'h00;
         `XOP_INC:  next_x = idx_lo + 8'h01;
         `XOP_DEC:  next_x = idx_lo - 8'h01;
         `XOP_COM:  next_x = ~idx_lo;
         `XOP_NEG:  next_x = 8'h00 - idx_lo;
         `XOP_LSL:  next_x = {idx_lo[6:0], 1'b0};
         `XOP_LSR:  next_x = {1'b0, idx_lo[7:1]};
         `XOP_ASR:  next_x = {idx_lo[7], idx_lo[7:1]};
         `XOP_ROL:  next_x = {idx_lo[6:0], x_carry_in};
         `XOP_ROR:  next_x = {x_carry_in, idx_lo[7:1]};
         `XOP_LOAD: next_x = load_data;
         default:   next_x = idx_lo;
      endcase
   end

   // index low keeps its value through reset
   always @(posedge clk)
   begin
      if (state == ST_RUN)
      begin
         if (mul_exec)
            idx_lo <= product[15:8];
         else if (div_exec)
            idx_lo <= idx_lo;                          // divisor kept
         else
            idx_lo <= next_x;
      end
   end

   // index high forced to zero at reset; holds remainder after divide
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         idx_hi <= `IDX_HI_RESET;
      else if (state == ST_RUN)
      begin
         if (div_exec)
            idx_hi <= remainder;
         else if (h_load)
            idx_hi <= load_data;
      end
   end

   // flags: carry tracks divide outcome; multiply clears carry and half carry unless a divide comes in the same cycle
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         flags <= 8'h08;                               // mask set at reset
      else if (state == ST_RUN)
      begin
         if (div_exec)
            flags[`FLAG_C] <= div_fault;
         else if (mul_exec)
         begin
            flags[`FLAG_H] <= 1'b0;
            flags[`FLAG_C] <= 1'b0;
         end
         else if (flags_load)
            flags <= flags_in & ~`FLAG_FIXED_MASK;
      end
   end

   // stack pointer next value; one update per cycle by priority
   // a load or adjust in the same cycle as a push wins, so the sequencer
   // must not overlap them if the push is meant to move the pointer
   always @*
   begin
      if (sp_load)
         next_sp = ext_addr;
      else if (stack_low_reload_instr)
         next_sp = {stack_pointer[15:8], 8'hFF};
      else if (stack_adjust_instr)
         next_sp = stack_pointer
                   + {{8{stack_imm[7]}}, stack_imm};
      else if (push)
         next_sp = stack_pointer - 16'h0001;
      else if (pull)
         next_sp = stack_pointer + 16'h0001;
      else
         next_sp = stack_pointer;
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         stack_pointer <= `SP_RESET;
      else if (state == ST_RUN)
         stack_pointer <= next_sp;
   end
endmodule
`default_nettype wire

//--- verif/mem_model.sv
// memory stand-in that answers the core's reads
`default_nettype none
module mem_model #(
   parameter logic [15:0] VEC = 16'hC13A
) (
   input  wire logic [15:0] mem_addr,
   output var  logic [7:0]  mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // other bytes vary with the address so a read from a stale address shows
   always_comb
      case (mem_addr)
         16'hFFFE: mem_rdata = VEC[15:8];
         16'hFFFF: mem_rdata = VEC[7:0];
         default:  mem_rdata = mem_addr[15:8] ^ mem_addr[7:0] ^ 8'h5A;
      endcase
endmodule
`default_nettype wire

//--- verif/cpu_register_set_chk.sv
// concurrent checks on the register set ports
`default_nettype none
`include "cpu_regs_regs.vh"
module cpu_register_set_chk (
   input wire logic        clk, arst_n, fetch, pc_load, branch_rel,
   input wire logic        stack_adjust_instr, stack_low_reload_instr,
   input wire logic        sp_load, push, pull, vector_busy,
   input wire logic [2:0]  addr_sel,
   input wire logic [7:0]  rel_disp, stack_imm, direct_addr, mem_rdata,
   input wire logic [7:0]  acc, idx_hi, idx_lo, condition_flags,
   input wire logic [7:0]  alu_operand_a,
   input wire logic [15:0] pc_target, index_pair, stack_pointer,
   input wire logic [15:0] program_counter, mem_addr
);
   logic        run;
   logic        sp_free;
   logic [15:0] rel_x;
   logic [15:0] imm_x;
   // controls count only once the vector load is over
   assign run = !vector_busy;
   assign sp_free = run && !sp_load && !stack_low_reload_instr
                    && !stack_adjust_instr;
   assign rel_x = {{8{rel_disp[7]}}, rel_disp};
   assign imm_x = {{8{stack_imm[7]}}, stack_imm};
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence vec_hi;
      vector_busy && mem_addr == `VEC_HI_ADDR;
   endsequence
   sequence vec_lo;
      vector_busy && mem_addr == `VEC_LO_ADDR;
   endsequence
   sequence push_step;
      mem_addr == stack_pointer
         ##1 stack_pointer == $past(mem_addr) - 16'h0001;
   endsequence
   AST_VECTOR:
      assert property ($rose(arst_n) |-> vec_hi ##1 vec_lo ##1 !vector_busy
         && program_counter == {$past(mem_rdata, 2), $past(mem_rdata)})
      else $error("reset vector load wrong");
   AST_RESET:
      assert property ($rose(arst_n) |->
         stack_pointer == `SP_RESET && idx_hi == `IDX_HI_RESET)
      else $error("reset values wrong");
   AST_FETCH:
      assert property (run && fetch && !pc_load && !branch_rel
         |=> program_counter == $past(program_counter) + 16'h0001)
      else $error("fetch did not advance");
   AST_JUMP:
      assert property (run && pc_load && !fetch && !branch_rel
         |=> program_counter == $past(pc_target))
      else $error("jump target not loaded");
   AST_BRANCH:
      assert property (run && branch_rel && !pc_load && !fetch
         |=> program_counter == $past(program_counter) + $past(rel_x))
      else $error("branch destination wrong");
   AST_ADJUST:
      assert property (run && stack_adjust_instr && !sp_load
         && !stack_low_reload_instr
         |=> stack_pointer == $past(stack_pointer) + $past(imm_x))
      else $error("stack adjust wrong");
   AST_RELOAD:
      assert property (run && stack_low_reload_instr && !sp_load
         |=> stack_pointer == ($past(stack_pointer) | 16'h00FF))
      else $error("stack low reload wrong");
   AST_PUSH:
      assert property (sp_free && push && addr_sel == `ASEL_PUSH
         |-> push_step)
      else $error("push address or pointer wrong");
   AST_PULL:
      assert property (sp_free && pull && !push && addr_sel == `ASEL_PULL
         |-> mem_addr == stack_pointer + 16'h0001
         ##1 stack_pointer == $past(mem_addr))
      else $error("pull address or pointer wrong");
   AST_DIRECT:
      assert property (run && addr_sel == `ASEL_DIRECT
         |-> mem_addr == {8'h00, direct_addr})
      else $error("direct address wrong");
   AST_INDEX:
      assert property (run && addr_sel == `ASEL_INDEX
         |-> mem_addr == index_pair && index_pair == {idx_hi, idx_lo})
      else $error("indexed address wrong");
   AST_FLAGS:
      assert property ((condition_flags & `FLAG_FIXED_MASK) == 8'h60)
      else $error("fixed flag bits not one");
   AST_OPERAND:
      assert property (alu_operand_a == acc)
      else $error("alu operand not accumulator");
endmodule
bind cpu_register_set cpu_register_set_chk chk (.*);
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the cpu register set
`default_nettype none
`include "cpu_regs_regs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] VEC = 16'hC13A; // arbitrary vector
   logic clk = 0, arst_n = 0, fetch = 0, pc_load = 0, branch_rel = 0;
   logic acc_load_alu = 0, acc_load_data = 0, h_load = 0, mul_exec = 0;
   logic div_exec = 0, flags_load = 0, stack_adjust_instr = 0, push = 0;
   logic stack_low_reload_instr = 0, sp_load = 0, pull = 0, vector_busy;
   logic [15:0] pc_target = '0, ext_addr = '0, r = 16'h6622; // 26146
   logic [7:0]  rel_disp = '0, alu_result = '0, load_data = '0, m;
   logic [7:0]  flags_in = '0, stack_imm = '0, direct_addr = '0;
   logic [7:0]  mem_rdata, acc, idx_hi, idx_lo, condition_flags;
   logic [7:0]  alu_operand_a, dsp[3] = '{8'h80, 8'h7F, 8'h05};
   logic [3:0]  x_op = '0;
   logic [2:0]  addr_sel = '0;
   logic [15:0] index_pair, stack_pointer, program_counter, mem_addr;
   int fail_count = 0, checks_done = 0, pc, sp, a = -1, x, h, i, t, e;
   int stk[$];
   always #20 clk = ~clk;
   cpu_register_set dut (.*);
   mem_model #(.VEC(VEC)) mem (.mem_addr(mem_addr), .mem_rdata(mem_rdata));
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task chk(input logic [15:0] g, input logic [15:0] w);
      checks_done++;
      if (g !== w)
      begin
         fail_count++;
         $display("Error at %0t: got %h want %h", $time, g, w);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one idle cycle between operations keeps each strobe a single pulse
   task done;
      @(negedge clk);
      {fetch, pc_load, branch_rel, acc_load_alu, acc_load_data} = '0;
      {h_load, mul_exec, div_exec, flags_load, stack_adjust_instr} = '0;
      {stack_low_reload_instr, sp_load, push, pull, x_op} = '0;
   endtask
   task rst;
      @(negedge clk);
      arst_n = 0;
      repeat (2) @(negedge clk);
      chk(stack_pointer, 16'h00FF);
      chk(idx_hi, 8'h00);
      if (a >= 0) chk({acc, idx_lo}, {a[7:0], x[7:0]});
      arst_n = 1;
      for (t = 0; t < 9 && vector_busy !== 1'b0; t++) @(negedge clk);
      if (vector_busy !== 1'b0)
      begin
         fail_count++;
         $display("Error at %0t: vector load timed out", $time);
         wrap_up;
      end
      {sp, h, pc} = {32'h00FF, 32'h0, 16'h0, VEC};
      chk(program_counter, VEC);
   endtask
   initial
   begin
      rst;
      for (i = 0; i < 3; i++)
      begin
         @(negedge clk);
         fetch = 1;
         done;
         pc++;
         chk(program_counter, pc);
      end
      r = nx(r);
      @(negedge clk);
      pc_load = 1;
      pc_target = r;
      done;
      pc = r;
      chk(program_counter, pc);
      for (i = 0; i < 3; i++)
      begin
         @(negedge clk);
         branch_rel = 1;
         rel_disp = dsp[i];
         done;
         pc += $signed(dsp[i]);
         chk(program_counter, pc);
      end
      $display("test flow done");
      r = nx(r);
      @(negedge clk);
      acc_load_data = 1;
      load_data = r[7:0];
      done;
      @(negedge clk);
      acc_load_alu = 1;
      alu_result = r[15:8];
      flags_load = 1;
      flags_in = 8'h91;
      done;
      a = r[15:8];
      chk({alu_operand_a, acc}, {a[7:0], a[7:0]});
      chk(condition_flags, 8'hF1);
      @(negedge clk);
      x_op = `XOP_LOAD;
      h_load = 1;
      load_data = 8'h80;
      done;
      {h, x} = {32'h80, 32'h80};
      // walk down from ror to clr; masks hide the carry-fed bit
      for (i = 10; i > 0; i--)
      begin
         @(negedge clk);
         x_op = i[3:0];
         done;
         case (i)
            1: x = 0;
            2: x++;
            3: x--;
            4: x = ~x;
            5: x = -x;
            6, 9: x = x << 1;
            7, 10: x = x >> 1;
            8: x = x >> 1 | x & 128;
         endcase
         x &= 255;
         m = i == 9 ? 8'hFE : i == 10 ? 8'h7F : 8'hFF;
         chk({idx_hi, idx_lo & m}, {h[7:0], x[7:0] & m});
      end
      @(negedge clk);
      div_exec = 1;
      done;
      {h, a} = {32'h0, 32'hFF};
      chk({idx_hi, acc}, 16'h00FF);
      chk(condition_flags[0], 1'b1);
      @(negedge clk);
      x_op = `XOP_LOAD;
      h_load = 1;
      load_data = 8'h3C;
      addr_sel = `ASEL_INDEX;
      done;
      {h, x} = {32'h3C, 32'h3C};
      chk(mem_addr, 16'h3C3C);
      @(negedge clk);
      mul_exec = 1;
      done;
      t = a * x;
      {a, x} = {t & 255, t >> 8};
      chk({idx_lo, acc}, t);
      r = nx(r);
      addr_sel = `ASEL_DIRECT;
      direct_addr = r[7:0];
      #1 chk(mem_addr, {8'h00, r[7:0]});
      $display("test data done");
      @(negedge clk);
      sp_load = 1;
      ext_addr = r;
      done;
      sp = r;
      // three pushes, two pulls, then both adjust extremes
      for (i = 0; i < 7; i++)
      begin
         @(negedge clk);
         push = i < 3;
         pull = i inside {3, 4};
         stack_adjust_instr = i > 4;
         stack_imm = i == 5 ? 8'h80 : 8'h7F;
         addr_sel = i < 3 ? `ASEL_PUSH : `ASEL_PULL;
         #1 e = i < 3 ? sp : i < 5 ? stk.pop_back() : 0;
         if (i < 3) stk.push_back(sp);
         if (i < 5) chk(mem_addr, e);
         done;
         sp += i < 3 ? -1 : i < 5 ? 1 : $signed(stack_imm);
         chk(stack_pointer, sp);
      end
      @(negedge clk);
      stack_low_reload_instr = 1;
      done;
      sp |= 255;
      chk(stack_pointer, sp);
      $display("test stack done");
      rst;
      $display("test reset done");
      wrap_up;
   end
endmodule
`default_nettype wire
